// >>> hdl/sfcf_defs.vh
`ifndef SFCF_DEFS_VH
`define SFCF_DEFS_VH

// Clock and tick timing
`define SFCF_CLK_NS 10
`define SFCF_TICK_NS 500
`define SFCF_TICK_CYC (`SFCF_TICK_NS / `SFCF_CLK_NS)
`define SFCF_TICK_LAST 9'h031

// Pulse lengths in ticks
`define SFCF_SYNC_TICKS 6'h38
`define SFCF_NIB_BASE 6'h0c
`define SFCF_PAUSE_TICKS 6'h0c

// Low time select codes and tick counts
`define SFCF_LOWT_3 2'h0
`define SFCF_LOWT_5 2'h2
`define SFCF_LOWT_6 2'h3
`define SFCF_LOW_3_TICKS 6'h03
`define SFCF_LOW_5_TICKS 6'h05
`define SFCF_LOW_6_TICKS 6'h06

// Fast channel format codes
`define SFCF_FMT_SINGLE 2'h0
`define SFCF_FMT_SECURE 2'h1
`define SFCF_FMT_DUAL 2'h2
`define SFCF_FMT_SECOND 2'h3

// Data nibble counts
`define SFCF_NDATA_3 4'h3
`define SFCF_NDATA_6 4'h6

// Secondary value select codes
`define SFCF_SEC_TEMP 2'h0
`define SFCF_SEC_FIELD 2'h1
`define SFCF_SEC_ANGLE 2'h2

// CRC
`define SFCF_CRC_SEED 4'h5
`define SFCF_CRC_POLY 4'hd

// Sample FIFO
`define SFCF_FIFO_WIDTH 24
`define SFCF_FIFO_DEPTH 4

`endif

// >>> hdl/sfcf_fifo.v
`timescale 1ns/1ps
`default_nettype none

module sfcf_fifo #(
	parameter WIDTH = 24,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	// Clock and reset
	input wire clk_sys_i,
	input wire reset_i,
	// Fill side
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	// Drain side
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);

	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;

	assign in_ready_o = (cnt_q != DEPTH[AW:0]);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o = mem_q[rd_q];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always @(posedge clk_sys_i) begin
		if (push) begin
			mem_q[wr_q] <= in_data_i;
		end
	end

	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

endmodule // sfcf_fifo

`default_nettype wire

// >>> hdl/sfcf_framer.v
// How it works
// - Dual-channel formats send six data nibbles between status and CRC
// - Dual-throttle: first three nibbles position, next three its negation
// - Position goes out MSN first in pulses three, four, five
// - Negated value goes out LSN first in pulses six, seven, eight
// - Secondary variant carries temperature, field or angle, picked by two select bits
// - Secondary value goes out LSN first in pulses six to eight
// - Transmitted position is limited to the low and high clamp values
// - Status bits 1:0 follow error setting, bits 3:2 follow serial setting
// - Every frame ends its data with a CRC nibble, variant chosen
// - Pause pulse follows CRC only when enabled, else next frame starts if a sample is queued, otherwise the line goes idle
// - Single-channel format sends three position nibbles, CRC, optional pause
// - Two-bit format field selects single, dual-throttle or secondary layout; the secure code sends the single layout
// - CRC select low picks the newer CRC, high the legacy CRC
// - Pause enable low gives back-to-back frames while samples are queued, high adds a pause
`timescale 1ns/1ps
`default_nettype none
`include "sfcf_defs.vh"

module sfcf_framer (
	// Clock and reset
	input wire clk_sys_i,
	input wire reset_i,
	// Measurement samples
	input wire sample_valid_i,
	output wire sample_ready_o,
	input wire [11:0] position_i,
	input wire [11:0] temperature_i,
	input wire [11:0] field_amp_i,
	input wire [11:0] angle2_i,
	// Setup
	input wire [1:0] fast_format_i,
	input wire [1:0] low_time_sel_i,
	input wire crc_legacy_i,
	input wire pause_pulse_enable_i,
	input wire err_status_en_i,
	input wire serial_en_i,
	input wire [1:0] secondary_sel_i,
	input wire [11:0] clamp_low_i,
	input wire [11:0] clamp_high_i,
	// Status sources
	input wire err_sensor_i,
	input wire err_func_i,
	input wire [1:0] serial_bits_i,
	// Line and state
	output wire sent_o,
	output wire frame_start_o,
	output wire busy_o
);

	////////////////////////////////////////////////////////////////////////////
	// States

	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_SYNC = 4'h2;
	localparam [3:0] ST_NIB = 4'h4;
	localparam [3:0] ST_PAUSE = 4'h8;
	localparam [8:0] TICK_LAST = `SFCF_TICK_LAST;

	reg [3:0] state_q;
	reg [8:0] tick_cyc_q;
	reg [5:0] tick_in_q;
	reg [5:0] pulse_len_q;
	reg [3:0] nib_idx_q;
	reg [1:0] fmt_q;
	reg [11:0] pos_q;
	reg [11:0] sec_q;
	reg [3:0] status_q;
	reg [3:0] crc_q;
	reg line_q;
	reg start_q;

	////////////////////////////////////////////////////////////////////////////
	// Functions

	// One CRC step: multiply by x^4 modulo the polynomial, then add nibble
	function [3:0] crc_step;
		input [3:0] c;
		input [3:0] d;
		integer i;
		reg [3:0] t;
		begin
			t = c;
			for (i = 0; i < 4; i = i + 1) begin
				t = {t[2:0], 1'b0} ^ (t[3] ? `SFCF_CRC_POLY : 4'h0);
			end
			crc_step = t ^ d;
		end
	endfunction

	function [3:0] ndata_of;
		input [1:0] fmt;
		begin
			if (fmt == `SFCF_FMT_DUAL || fmt == `SFCF_FMT_SECOND) begin
				ndata_of = `SFCF_NDATA_6;
			end else begin
				ndata_of = `SFCF_NDATA_3;
			end
		end
	endfunction

	// Data nibble k (1-based) of a frame
	function [3:0] data_nib;
		input [1:0] fmt;
		input [3:0] k;
		input [11:0] pos;
		input [11:0] sec;
		reg [11:0] v;
		begin
			v = (fmt == `SFCF_FMT_DUAL) ? ~pos : sec;
			case (k)
				4'h1: data_nib = pos[11:8];
				4'h2: data_nib = pos[7:4];
				4'h3: data_nib = pos[3:0];
				4'h4: data_nib = v[3:0];
				4'h5: data_nib = v[7:4];
				4'h6: data_nib = v[11:8];
				default: data_nib = 4'h0;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Sample path: clamp, secondary select, FIFO

	reg [11:0] pos_clamped;
	reg [11:0] sec_pick;
	wire fifo_valid;
	wire fifo_pop;
	wire [23:0] fifo_data;

	always @* begin
		if (position_i < clamp_low_i) begin
			pos_clamped = clamp_low_i;
		end else if (position_i > clamp_high_i) begin
			pos_clamped = clamp_high_i;
		end else begin
			pos_clamped = position_i;
		end
		case (secondary_sel_i)
			`SFCF_SEC_FIELD: sec_pick = field_amp_i;
			`SFCF_SEC_ANGLE: sec_pick = angle2_i;
			default: sec_pick = temperature_i;
		endcase
	end

	sfcf_fifo #(
		.WIDTH(`SFCF_FIFO_WIDTH),
		.DEPTH(`SFCF_FIFO_DEPTH),
		.AW(2)
	) u_fifo (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.in_valid_i(sample_valid_i),
		.in_ready_o(sample_ready_o),
		.in_data_i({pos_clamped, sec_pick}),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Tick timing

	reg [5:0] low_ticks;
	wire tick;
	wire pulse_end;
	wire in_frame;
	wire [3:0] ndata;
	wire [3:0] next_idx;
	wire [3:0] crc_final;
	wire [3:0] status_nib;

	always @* begin
		case (low_time_sel_i)
			`SFCF_LOWT_5: low_ticks = `SFCF_LOW_5_TICKS;
			`SFCF_LOWT_6: low_ticks = `SFCF_LOW_6_TICKS;
			default: low_ticks = `SFCF_LOW_3_TICKS;
		endcase
	end

	assign in_frame = (state_q != ST_IDLE);
	assign tick = in_frame && (tick_cyc_q == TICK_LAST);
	assign pulse_end = tick && (tick_in_q == pulse_len_q - 6'h01);
	assign ndata = ndata_of(fmt_q);
	assign next_idx = nib_idx_q + 4'h1;
	assign crc_final = crc_legacy_i ? crc_q : crc_step(crc_q, 4'h0);
	assign status_nib[1:0] = err_status_en_i ? {err_func_i, err_sensor_i} : 2'h0;
	assign status_nib[3:2] = serial_en_i ? serial_bits_i : 2'h0;

	// Next frame may start only with a fresh sample in hand
	reg start_now;
	always @* begin
		start_now = 1'b0;
		if (state_q == ST_IDLE) begin
			start_now = fifo_valid;
		end else if (pulse_end && state_q == ST_PAUSE) begin
			start_now = fifo_valid;
		end else if (pulse_end && state_q == ST_NIB && nib_idx_q == ndata + 4'h1) begin
			start_now = fifo_valid && !pause_pulse_enable_i;
		end
	end
	assign fifo_pop = start_now;

	////////////////////////////////////////////////////////////////////////////
	// Frame sequencer

	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			state_q <= ST_IDLE;
			tick_cyc_q <= 9'h000;
			tick_in_q <= 6'h00;
			pulse_len_q <= `SFCF_SYNC_TICKS;
			nib_idx_q <= 4'h0;
			fmt_q <= `SFCF_FMT_SINGLE;
			pos_q <= 12'h000;
			sec_q <= 12'h000;
			status_q <= 4'h0;
			crc_q <= `SFCF_CRC_SEED;
			line_q <= 1'b1;
			start_q <= 1'b0;
		end else begin
			start_q <= start_now;
			if (start_now) begin
				state_q <= ST_SYNC;
				tick_cyc_q <= 9'h000;
				tick_in_q <= 6'h00;
				pulse_len_q <= `SFCF_SYNC_TICKS;
				nib_idx_q <= 4'h0;
				fmt_q <= fast_format_i;
				pos_q <= fifo_data[23:12];
				sec_q <= fifo_data[11:0];
				status_q <= status_nib;
				crc_q <= `SFCF_CRC_SEED;
				line_q <= 1'b0;
			end else if (in_frame) begin
				tick_cyc_q <= tick ? 9'h000 : tick_cyc_q + 9'h001;
				if (pulse_end) begin
					tick_in_q <= 6'h00;
					line_q <= 1'b0;
					case (state_q)
						ST_SYNC: begin
							state_q <= ST_NIB;
							nib_idx_q <= 4'h0;
							pulse_len_q <= `SFCF_NIB_BASE + {2'h0, status_q};
						end
						ST_NIB: begin
							if (nib_idx_q == ndata + 4'h1) begin
								if (pause_pulse_enable_i) begin
									state_q <= ST_PAUSE;
									pulse_len_q <= `SFCF_PAUSE_TICKS;
								end else begin
									state_q <= ST_IDLE;
									line_q <= 1'b1;
								end
							end else if (nib_idx_q == ndata) begin
								nib_idx_q <= next_idx;
								pulse_len_q <= `SFCF_NIB_BASE + {2'h0, crc_final};
							end else begin
								nib_idx_q <= next_idx;
								pulse_len_q <= `SFCF_NIB_BASE
									+ {2'h0, data_nib(fmt_q, next_idx, pos_q, sec_q)};
								crc_q <= crc_step(crc_q, data_nib(fmt_q, next_idx, pos_q, sec_q));
							end
						end
						default: begin
							state_q <= ST_IDLE;
							line_q <= 1'b1;
						end
					endcase
				end else if (tick) begin
					tick_in_q <= tick_in_q + 6'h01;
					if (tick_in_q + 6'h01 == low_ticks) begin
						line_q <= 1'b1;
					end
				end
			end else begin
				line_q <= 1'b1;
			end
		end
	end

	assign sent_o = line_q;
	assign frame_start_o = start_q;
	assign busy_o = in_frame;

endmodule // sfcf_framer

`default_nettype wire

// >>> testbench/sfcf_framer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfcf_defs.vh"
module sfcf_framer_asserts (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Watched ports
	input wire logic sample_valid_i,
	input wire logic sample_ready_o,
	input wire logic [1:0] fast_format_i,
	input wire logic [1:0] low_time_sel_i,
	input wire logic sent_o,
	input wire logic frame_start_o,
	input wire logic busy_o
);
	localparam int T = `SFCF_TICK_CYC;
	logic prev_q;
	logic sync_q;
	logic fall;
	logic [3:0] cnt_q;
	int gap_q;
	int low_q;
	int tk;
	int low_exp;
	assign fall = prev_q & ~sent_o;
	assign tk = gap_q / T;
	assign low_exp = T * (low_time_sel_i == 2'h2 ? 5 : low_time_sel_i == 2'h3 ? 6 : 3);
	// Edge, interval and queue tracking
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			prev_q <= 1'b1;
			sync_q <= 1'b0;
			cnt_q <= 4'h0;
			gap_q <= 0;
			low_q <= 0;
		end else begin
			prev_q <= sent_o;
			sync_q <= frame_start_o | (sync_q & ~fall);
			cnt_q <= cnt_q + 4'(sample_valid_i & sample_ready_o) - 4'(frame_start_o);
			gap_q <= fall ? 1 : gap_q + 1;
			low_q <= sent_o ? 0 : low_q + 1;
		end
	end
	////////////////////////////////
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	a_reset_idle: assert property (disable iff (1'b0)
		reset_i |=> sent_o && !busy_o && sample_ready_o) else $error("not idle after reset");
	a_sync_len: assert property (fall && sync_q |-> gap_q == 56 * T)
		else $error("sync length wrong");
	a_nib_ticks: assert property (fall && $past(busy_o) |->
		gap_q % T == 0 && (tk == 56 || (tk >= 12 && tk <= 27))) else $error("bad interval");
	a_low_time: assert property (!prev_q && sent_o |-> low_q == low_exp)
		else $error("low time wrong");
	a_start_edge: assert property (frame_start_o |->
		!sent_o && $past(sent_o)) else $error("start not at fall");
	a_start_once: assert property (frame_start_o |=> !frame_start_o [*8])
		else $error("start pulse repeated");
	a_idle_high: assert property (!busy_o |-> sent_o)
		else $error("line low while idle");
	a_ready_full: assert property (!sample_ready_o |-> cnt_q >= 4'h4)
		else $error("refused while not full");
	a_queued_go: assert property (!busy_o && cnt_q != 4'h0 |-> ##[1:3] frame_start_o)
		else $error("queued word not sent");
	c_dual: cover property (frame_start_o && fast_format_i == 2'h2);
	c_second: cover property (frame_start_o && fast_format_i == 2'h3);
	c_single: cover property (frame_start_o && fast_format_i == 2'h0);
	c_full: cover property (!sample_ready_o);
endmodule // sfcf_framer_asserts
bind sfcf_framer sfcf_framer_asserts i_chk (
	.clk_sys_i(clk_sys_i),
	.reset_i(reset_i),
	.sample_valid_i(sample_valid_i),
	.sample_ready_o(sample_ready_o),
	.fast_format_i(fast_format_i),
	.low_time_sel_i(low_time_sel_i),
	.sent_o(sent_o),
	.frame_start_o(frame_start_o),
	.busy_o(busy_o)
);
`default_nettype wire

// >>> testbench/sfcf_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfcf_rx_model (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Line
	input wire logic sent_i,
	// Decoded
	output logic sync_stb_o,
	output logic nib_stb_o,
	output logic [3:0] nib_o
);
	logic prev_q;
	logic armed_q;
	int gap_q;
	int tick_q;
	// Falling edge interval decoder
	always @(posedge clk_sys_i) begin
		sync_stb_o <= 1'b0;
		nib_stb_o <= 1'b0;
		if (reset_i) begin
			prev_q <= 1'b1;
			armed_q <= 1'b0;
			gap_q <= 0;
			tick_q <= 1;
		end else begin
			prev_q <= sent_i;
			gap_q <= gap_q + 1;
			if (prev_q && !sent_i) begin
				gap_q <= 1;
				if (gap_q > 2000 && gap_q < 4000) begin
					tick_q <= gap_q / 56;
					armed_q <= 1'b1;
					sync_stb_o <= 1'b1;
				end else if (armed_q) begin
					nib_stb_o <= 1'b1;
					nib_o <= 4'((gap_q + tick_q / 2) / tick_q - 12);
				end
			end
		end
	end
endmodule // sfcf_rx_model
`default_nettype wire

// >>> testbench/sfcf_framer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfcf_defs.vh"
module sfcf_framer_tb;
	logic clk_sys_i = 1'b0, reset_i = 1'b1, sample_valid_i = 1'b0;
	logic [11:0] position_i = 12'h0, clamp_low_i = 12'h0, clamp_high_i = 12'hfff;
	logic [1:0] secondary_sel_i = 2'h0, fast_format_i = 2'h1, low_time_sel_i = 2'h1;
	logic [1:0] serial_bits_i = 2'h2;
	logic crc_legacy_i = 1'b0, pause_pulse_enable_i = 1'b0, err_status_en_i = 1'b1;
	logic serial_en_i = 1'b1, err_sensor_i = 1'b1, err_func_i = 1'b0;
	wire sample_ready_o, sent_o, frame_start_o, busy_o, sync_stb, nib_stb;
	wire [3:0] nib;
	logic [4:0] rxq[$];
	logic [4:0] expq[$];
	int bad_count = 0;
	int num_checks = 0;
	time t_fall = 0;
	always #5 clk_sys_i = ~clk_sys_i;
	sfcf_framer i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
		.position_i(position_i), .temperature_i(12'h0c1), .field_amp_i(12'h2d3),
		.angle2_i(12'h3e4), .fast_format_i(fast_format_i), .low_time_sel_i(low_time_sel_i),
		.crc_legacy_i(crc_legacy_i), .pause_pulse_enable_i(pause_pulse_enable_i),
		.err_status_en_i(err_status_en_i), .serial_en_i(serial_en_i),
		.secondary_sel_i(secondary_sel_i), .clamp_low_i(clamp_low_i),
		.clamp_high_i(clamp_high_i), .err_sensor_i(err_sensor_i), .err_func_i(err_func_i),
		.serial_bits_i(serial_bits_i), .sent_o(sent_o), .frame_start_o(frame_start_o),
		.busy_o(busy_o));
	sfcf_rx_model i_rx (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sent_i(sent_o),
		.sync_stb_o(sync_stb), .nib_stb_o(nib_stb), .nib_o(nib));
	always @(posedge clk_sys_i) begin
		if (sync_stb) rxq.push_back(5'h10);
		else if (nib_stb) rxq.push_back({1'b0, nib});
	end
	always @(negedge sent_o) t_fall = $time;
	////////////////////////////////
	task automatic check_val(input logic [4:0] got, input logic [4:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [3:0] step(input logic [3:0] c, input logic [3:0] x);
		for (int k = 0; k < 4; k++) c = c[3] ? {c[2:0], 1'b0} ^ `SFCF_CRC_POLY : {c[2:0], 1'b0};
		return c ^ x;
	endfunction
	task automatic add_frame(input logic [3:0] st, input logic [23:0] d, input int n, input logic l);
		logic [3:0] c;
		c = `SFCF_CRC_SEED;
		expq.push_back(5'h10);
		expq.push_back({1'b0, st});
		for (int k = 0; k < n; k++) begin
			expq.push_back({1'b0, d[23 - 4 * k -: 4]});
			c = step(c, d[23 - 4 * k -: 4]);
		end
		if (!l) c = step(c, 4'h0);
		expq.push_back({1'b0, c});
	endtask
	task automatic push(input logic [11:0] p, lo, hi, input logic [1:0] sel);
		@(posedge clk_sys_i);
		sample_valid_i <= 1'b1;
		position_i <= p;
		clamp_low_i <= lo;
		clamp_high_i <= hi;
		secondary_sel_i <= sel;
		@(negedge clk_sys_i);
		while (sample_ready_o !== 1'b1) @(negedge clk_sys_i);
		@(posedge clk_sys_i);
		sample_valid_i <= 1'b0;
	endtask
	task automatic stage();
		@(negedge clk_sys_i);
		while (frame_start_o !== 1'b1) @(negedge clk_sys_i);
		while (sent_o !== 1'b1) @(negedge clk_sys_i);
		@(posedge clk_sys_i);
	endtask
	////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		repeat (5) push(12'h0, 12'h0, 12'hfff, 2'h2);
		@(negedge clk_sys_i);
		check_val({4'h0, sample_ready_o}, 5'h0);
		check_val({4'h0, busy_o}, 5'h1);
		@(posedge clk_sys_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		fast_format_i <= 2'h2;
		low_time_sel_i <= 2'h0;
		@(negedge clk_sys_i);
		check_val({3'h0, sent_o, busy_o}, 5'h2);
		check_val({4'h0, sample_ready_o}, 5'h1);
		push(12'hf00, 12'h010, 12'h7c3, 2'h3);
		stage();
		fast_format_i <= 2'h3;
		err_status_en_i <= 1'b0;
		serial_bits_i <= 2'h1;
		push(12'h001, 12'h020, 12'hfff, 2'h1);
		push(12'h123, 12'h000, 12'hfff, 2'h0);
		position_i <= 12'hfff;
		add_frame(4'h9, 24'h7c3c38, 6, 1'b0);
		add_frame(4'h4, 24'h0203d2, 6, 1'b1);
		add_frame(4'h2, 24'h123000, 3, 1'b0);
		stage();
		low_time_sel_i <= 2'h2;
		crc_legacy_i <= 1'b1;
		fast_format_i <= 2'h0;
		err_status_en_i <= 1'b1;
		serial_en_i <= 1'b0;
		err_sensor_i <= 1'b0;
		err_func_i <= 1'b1;
		stage();
		low_time_sel_i <= 2'h3;
		crc_legacy_i <= 1'b0;
		pause_pulse_enable_i <= 1'b1;
		@(negedge clk_sys_i);
		while (busy_o !== 1'b0) @(negedge clk_sys_i);
		check_val({4'h0, ($time - t_fall) / 10 inside
			{[12 * `SFCF_TICK_CYC - 5 : 12 * `SFCF_TICK_CYC + 5]}}, 5'h1);
		check_val(5'(rxq.size()), 5'(expq.size()));
		foreach (expq[k]) check_val(rxq[k], expq[k]);
		conclude();
	end
	initial begin
		#600000;
		bad_count++;
		conclude();
	end
endmodule // sfcf_framer_tb
`default_nettype wire
